/* hdl/pgpio_pkg.sv */
package pgpio_pkg;

   // register indices; byte address is four times the index
   localparam logic [15:0] PGPIO_IDX_DATA_LOW  = 16'h4405;
   localparam logic [15:0] PGPIO_IDX_OE_HIGH   = 16'h4406;
   localparam logic [15:0] PGPIO_IDX_DIR_HIGH  = 16'h4407;

   localparam int          PGPIO_ADDR_W        = 18;
   localparam int          PGPIO_DATA_W        = 32;
   localparam int          PGPIO_LOW_PINS      = 16;
   localparam int          PGPIO_HIGH_PINS     = 14;
   localparam int          PGPIO_REG_W         = 16;
   localparam int          PGPIO_FIRST_PIN     = 16;

   localparam logic [15:0] PGPIO_OE_RESET      = 16'h0000;
   localparam logic [15:0] PGPIO_DIR_RESET     = 16'h0000;
   localparam logic [1:0]  PGPIO_RESP_OKAY     = 2'h0;
   localparam logic [1:0]  PGPIO_RESP_SLVERR   = 2'h2;
   localparam int          PGPIO_SYNC_STAGES   = 2;

   // drive side of the low pin group
   typedef struct packed {
      logic [15:0] out;
      logic [15:0] oe;
   } pgpio_drive_t;

   // high group control as seen by the sibling pin logic
   typedef struct packed {
      logic [13:0] oe;
      logic [13:0] dir;
   } pgpio_high_ctl_t;

endpackage

/* hdl/pgpio_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// two flip-flop level synchroniser, one per bit
module pgpio_sync #(
   parameter int WIDTH = 16
) (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic [WIDTH-1:0] async_in,
   output var  logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta_q <= '0;
         sync_q <= '0;
      end
      else
      begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;

endmodule

`default_nettype wire

/* hdl/pgpio_regs.sv */
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module pgpio_regs #(
   parameter int LOW_PINS  = pgpio_pkg::PGPIO_LOW_PINS,
   parameter int HIGH_PINS = pgpio_pkg::PGPIO_HIGH_PINS
) (
   input  wire logic                                 aclk,
   input  wire logic                                 aresetn,
   input  wire logic [pgpio_pkg::PGPIO_ADDR_W-1:0]   s_axil_awaddr,
   input  wire logic                                 s_axil_awvalid,
   output var  logic                                 s_axil_awready,
   input  wire logic [pgpio_pkg::PGPIO_DATA_W-1:0]   s_axil_wdata,
   input  wire logic [3:0]                           s_axil_wstrb,
   input  wire logic                                 s_axil_wvalid,
   output var  logic                                 s_axil_wready,
   output var  logic [1:0]                           s_axil_bresp,
   output var  logic                                 s_axil_bvalid,
   input  wire logic                                 s_axil_bready,
   input  wire logic [pgpio_pkg::PGPIO_ADDR_W-1:0]   s_axil_araddr,
   input  wire logic                                 s_axil_arvalid,
   output var  logic                                 s_axil_arready,
   output var  logic [pgpio_pkg::PGPIO_DATA_W-1:0]   s_axil_rdata,
   output var  logic [1:0]                           s_axil_rresp,
   output var  logic                                 s_axil_rvalid,
   input  wire logic                                 s_axil_rready,
   input  wire logic [LOW_PINS-1:0]                  port_pin_in,
   input  wire logic [LOW_PINS-1:0]                  low_output_enable,
   input  wire logic [LOW_PINS-1:0]                  low_direction,
   output var  pgpio_pkg::pgpio_drive_t              port_pin_drive,
   output var  pgpio_pkg::pgpio_high_ctl_t           high_ctl
);

   import pgpio_pkg::*;

   // register state
   logic [PGPIO_REG_W-1:0]  data_q;
   logic [PGPIO_REG_W-1:0]  data_d;
   logic [PGPIO_REG_W-1:0]  oe_q;
   logic [PGPIO_REG_W-1:0]  oe_d;
   logic [PGPIO_REG_W-1:0]  dir_q;
   logic [PGPIO_REG_W-1:0]  dir_d;

   // write channel state
   logic                    aw_hold_q;
   logic [15:0]             aw_idx_q;
   logic                    w_hold_q;
   logic [PGPIO_REG_W-1:0]  w_data_q;
   logic [1:0]              w_strb_q;
   logic                    bvalid_q;
   logic [1:0]              bresp_q;

   // read channel state
   logic                    rvalid_q;
   logic [PGPIO_DATA_W-1:0] rdata_q;
   logic [1:0]              rresp_q;

   // pin sampling
   logic [LOW_PINS-1:0]     pin_sync;

   pgpio_sync #(
      .WIDTH    (LOW_PINS)
   ) u_pin_sync (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .async_in (port_pin_in),
      .sync_out (pin_sync)
   );

   // write handshake and merge of address and data
   wire                    aw_take    = s_axil_awvalid & s_axil_awready;
   wire                    w_take     = s_axil_wvalid & s_axil_wready;
   wire                    have_aw    = aw_hold_q | aw_take;
   wire                    have_w     = w_hold_q | w_take;
   wire                    wr_fire    = have_aw & have_w;
   wire [15:0]             wr_idx     = aw_hold_q ? aw_idx_q
                                                  : s_axil_awaddr[PGPIO_ADDR_W-1:2];
   wire [PGPIO_REG_W-1:0]  wr_data    = w_hold_q ? w_data_q : s_axil_wdata[15:0];
   wire [1:0]              wr_strb    = w_hold_q ? w_strb_q : s_axil_wstrb[1:0];
   wire [PGPIO_REG_W-1:0]  wr_mask    = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

   wire                    wr_data_hit = wr_idx == PGPIO_IDX_DATA_LOW;
   wire                    wr_oe_hit   = wr_idx == PGPIO_IDX_OE_HIGH;
   wire                    wr_dir_hit  = wr_idx == PGPIO_IDX_DIR_HIGH;
   wire                    wr_mapped   = wr_data_hit | wr_oe_hit | wr_dir_hit;

   assign s_axil_awready = ~aw_hold_q & ~bvalid_q;
   assign s_axil_wready  = ~w_hold_q & ~bvalid_q;
   assign s_axil_bvalid  = bvalid_q;
   assign s_axil_bresp   = bresp_q;

   // next register values on a write, bytes gated by strobes
   assign data_d = (wr_fire & wr_data_hit) ? ((data_q & ~wr_mask) | (wr_data & wr_mask))
                                           : data_q;
   assign oe_d   = (wr_fire & wr_oe_hit)   ? ((oe_q & ~wr_mask) | (wr_data & wr_mask))
                                           : oe_q;
   assign dir_d  = (wr_fire & wr_dir_hit)  ? ((dir_q & ~wr_mask) | (wr_data & wr_mask))
                                           : dir_q;

   // read decode
   wire                    ar_take     = s_axil_arvalid & s_axil_arready;
   wire [15:0]             rd_idx      = s_axil_araddr[PGPIO_ADDR_W-1:2];
   wire                    rd_data_hit = rd_idx == PGPIO_IDX_DATA_LOW;
   wire                    rd_oe_hit   = rd_idx == PGPIO_IDX_OE_HIGH;
   wire                    rd_dir_hit  = rd_idx == PGPIO_IDX_DIR_HIGH;
   wire                    rd_mapped   = rd_data_hit | rd_oe_hit | rd_dir_hit;

   // input-mode bits read the pin, output-mode bits read the stored value
   wire [LOW_PINS-1:0]     input_mode  = ~low_direction;
   wire [PGPIO_REG_W-1:0]  data_view   = (pin_sync & input_mode)
                                       | (data_q & ~input_mode);
   wire [PGPIO_REG_W-1:0]  rd_word     = rd_data_hit ? data_view
                                       : rd_oe_hit   ? oe_q
                                       : rd_dir_hit  ? dir_q
                                       : '0;

   assign s_axil_arready = ~rvalid_q;
   assign s_axil_rvalid  = rvalid_q;
   assign s_axil_rdata   = rdata_q;
   assign s_axil_rresp   = rresp_q;

   // pin drive for the low group
   assign port_pin_drive.oe  = low_output_enable;
   assign port_pin_drive.out = data_q;

   // high group control out to its pin logic
   assign high_ctl.oe  = oe_q[HIGH_PINS-1:0];
   assign high_ctl.dir = dir_q[HIGH_PINS-1:0];

   // data register, reset loads the raw pin level from port_pin_in, not the synchroniser output
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         data_q <= port_pin_in;
      else
         data_q <= data_d;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         oe_q  <= PGPIO_OE_RESET;
         dir_q <= PGPIO_DIR_RESET;
      end
      else
      begin
         oe_q  <= oe_d;
         dir_q <= dir_d;
      end
   end

   // write address holding
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold_q <= 1'b0;
         aw_idx_q  <= '0;
      end
      else if (wr_fire)
         aw_hold_q <= 1'b0;
      else if (aw_take)
      begin
         aw_hold_q <= 1'b1;
         aw_idx_q  <= s_axil_awaddr[PGPIO_ADDR_W-1:2];
      end
   end

   // write data holding
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_hold_q <= 1'b0;
         w_data_q <= '0;
         w_strb_q <= '0;
      end
      else if (wr_fire)
         w_hold_q <= 1'b0;
      else if (w_take)
      begin
         w_hold_q <= 1'b1;
         w_data_q <= s_axil_wdata[15:0];
         w_strb_q <= s_axil_wstrb[1:0];
      end
   end

   // write response
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_q <= 1'b0;
         bresp_q  <= PGPIO_RESP_OKAY;
      end
      else if (wr_fire)
      begin
         bvalid_q <= 1'b1;
         bresp_q  <= wr_mapped ? PGPIO_RESP_OKAY : PGPIO_RESP_SLVERR;
      end
      else if (s_axil_bready)
         bvalid_q <= 1'b0;
   end

   // read response
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_q <= 1'b0;
         rdata_q  <= '0;
         rresp_q  <= PGPIO_RESP_OKAY;
      end
      else if (ar_take)
      begin
         rvalid_q <= 1'b1;
         rdata_q  <= {16'h0000, rd_word};
         rresp_q  <= rd_mapped ? PGPIO_RESP_OKAY : PGPIO_RESP_SLVERR;
      end
      else if (s_axil_rready)
         rvalid_q <= 1'b0;
   end

endmodule

`default_nettype wire

/* tb/pgpio_pins_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pgpio_pins_model (
   input  wire pgpio_pkg::pgpio_drive_t port_pin_drive,
   input  wire logic [15:0]             ext_level,
   output var  logic [15:0]             pin_level
);
   import pgpio_pkg::*;
   // driven bits follow the block, the rest follow the board
   assign pin_level = (port_pin_drive.oe & port_pin_drive.out)
                    | (~port_pin_drive.oe & ext_level);
endmodule
`default_nettype wire

/* tb/pgpio_regs_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module pgpio_regs_asserts
   import pgpio_pkg::*;
(
   input wire logic            aclk,
   input wire logic            aresetn,
   input wire logic            s_axil_awvalid,
   input wire logic            s_axil_awready,
   input wire logic            s_axil_wvalid,
   input wire logic            s_axil_wready,
   input wire logic [1:0]      s_axil_bresp,
   input wire logic            s_axil_bvalid,
   input wire logic            s_axil_bready,
   input wire logic            s_axil_arvalid,
   input wire logic            s_axil_arready,
   input wire logic [31:0]     s_axil_rdata,
   input wire logic            s_axil_rvalid,
   input wire logic            s_axil_rready,
   input wire logic [15:0]     low_output_enable,
   input wire pgpio_drive_t    port_pin_drive,
   input wire pgpio_high_ctl_t high_ctl
);
   logic wr_take;
   assign wr_take = s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence rd_wait_s;
      s_axil_rvalid && !s_axil_rready;
   endsequence
   write_answer_a: assert property (wr_take |=> s_axil_bvalid)
      else $error("write not answered");
   resp_hold_a: assert property (s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid)
      else $error("write answer dropped");
   read_answer_a: assert property (s_axil_arvalid && s_axil_arready |=> s_axil_rvalid)
      else $error("read not answered");
   read_hold_a: assert property (rd_wait_s |=> s_axil_rvalid && $stable(s_axil_rdata))
      else $error("read data moved");
   rdata_upper_a: assert property (s_axil_rvalid |-> !s_axil_arready && !s_axil_rdata[31:16])
      else $error("read word malformed");
   drive_hold_a: assert property (!wr_take |=> $stable(port_pin_drive.out))
      else $error("drive value moved");
   ctl_reset_a: assert property (disable iff (1'b0) !aresetn |=> high_ctl == '0)
      else $error("control not cleared");
   oe_follow_a: assert property (port_pin_drive.oe == low_output_enable)
      else $error("enable mismatch");
endmodule
bind pgpio_regs pgpio_regs_asserts i_pgpio_regs_asserts (
   .aclk, .aresetn, .s_axil_awvalid, .s_axil_awready, .s_axil_wvalid, .s_axil_wready,
   .s_axil_bresp, .s_axil_bvalid, .s_axil_bready, .s_axil_arvalid, .s_axil_arready,
   .s_axil_rdata, .s_axil_rvalid, .s_axil_rready, .low_output_enable, .port_pin_drive,
   .high_ctl
);
`default_nettype wire

/* tb/pgpio_regs_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module pgpio_regs_bench;
   import pgpio_pkg::*;
   logic            aclk, aresetn;
   logic [17:0]     s_axil_awaddr, s_axil_araddr;
   logic [31:0]     s_axil_wdata, s_axil_rdata;
   logic [3:0]      s_axil_wstrb;
   logic [1:0]      s_axil_bresp, s_axil_rresp;
   logic            s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready;
   logic            s_axil_bvalid, s_axil_bready, s_axil_arvalid, s_axil_arready;
   logic            s_axil_rvalid, s_axil_rready;
   logic [15:0]     ext, port_pin_in, low_output_enable, low_direction;
   pgpio_drive_t    port_pin_drive;
   pgpio_high_ctl_t high_ctl;
   int              miscompares = 0;
   int              num_checks = 0;
   pgpio_regs i_pgpio_regs (
      .aclk, .aresetn, .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready, .s_axil_wdata,
      .s_axil_wstrb, .s_axil_wvalid, .s_axil_wready, .s_axil_bresp, .s_axil_bvalid,
      .s_axil_bready, .s_axil_araddr, .s_axil_arvalid, .s_axil_arready, .s_axil_rdata,
      .s_axil_rresp, .s_axil_rvalid, .s_axil_rready, .port_pin_in, .low_output_enable,
      .low_direction, .port_pin_drive, .high_ctl
   );
   pgpio_pins_model i_pgpio_pins_model (
      .port_pin_drive, .ext_level(ext), .pin_level(port_pin_in)
   );
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [15:0] idx, input logic [15:0] d, input logic [1:0] er);
      s_axil_awaddr <= {idx, 2'h0};
      s_axil_wdata <= {16'h0, d};
      s_axil_awvalid <= 1'b1;
      s_axil_wvalid <= 1'b1;
      s_axil_bready <= 1'b1;
      fork
         begin
            do @(posedge aclk); while (!s_axil_awready);
            s_axil_awvalid <= 1'b0;
         end
         begin
            do @(posedge aclk); while (!s_axil_wready);
            s_axil_wvalid <= 1'b0;
         end
      join
      do @(posedge aclk); while (!s_axil_bvalid);
      s_axil_bready <= 1'b0;
      chk("bresp", {30'h0, s_axil_bresp}, {30'h0, er});
      // let an edge pass so the next call never re-raises bready in this step
      @(posedge aclk);
   endtask
   task automatic rd(input logic [15:0] idx, input logic [31:0] exp, input logic [1:0] er);
      s_axil_araddr <= {idx, 2'h0};
      s_axil_arvalid <= 1'b1;
      s_axil_rready <= 1'b1;
      do @(posedge aclk); while (!s_axil_arready);
      s_axil_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axil_rvalid);
      s_axil_rready <= 1'b0;
      chk("rdata", s_axil_rdata, exp);
      chk("rresp", {30'h0, s_axil_rresp}, {30'h0, er});
      // let an edge pass so the next call never re-raises rready in this step
      @(posedge aclk);
   endtask
   task automatic conclude();
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   initial
   begin
      #(5000 * 40);
      miscompares++;
      conclude();
   end
   initial
   begin
      {aresetn, s_axil_awvalid, s_axil_wvalid, s_axil_bready} = '0;
      {s_axil_arvalid, s_axil_rready, s_axil_awaddr, s_axil_araddr, s_axil_wdata} = '0;
      s_axil_wstrb = 4'hf;
      ext = 16'ha5c3;
      low_output_enable = 16'h0;
      low_direction = 16'h0;
      repeat (20) @(posedge aclk);
      chk("out", port_pin_drive.out, 32'ha5c3);
      aresetn <= 1'b1;
      low_output_enable <= 16'hffff;
      low_direction <= 16'hffff;
      ext <= 16'h0;
      rd(PGPIO_IDX_OE_HIGH, 32'h0, PGPIO_RESP_OKAY);
      rd(PGPIO_IDX_DIR_HIGH, 32'h0, PGPIO_RESP_OKAY);
      chk("pins", port_pin_in, 32'ha5c3);
      wr(PGPIO_IDX_OE_HIGH, 16'hffff, PGPIO_RESP_OKAY);
      wr(PGPIO_IDX_DIR_HIGH, 16'hffff, PGPIO_RESP_OKAY);
      rd(PGPIO_IDX_OE_HIGH, 32'hffff, PGPIO_RESP_OKAY);
      rd(PGPIO_IDX_DIR_HIGH, 32'hffff, PGPIO_RESP_OKAY);
      chk("high", {4'h0, high_ctl}, 32'h0fffffff);
      $display("test reset and control done");
      wr(PGPIO_IDX_DATA_LOW, 16'h1234, PGPIO_RESP_OKAY);
      chk("pins", port_pin_in, 32'h1234);
      rd(PGPIO_IDX_DATA_LOW, 32'h1234, PGPIO_RESP_OKAY);
      $display("test output mode done");
      low_output_enable <= 16'h0;
      low_direction <= 16'h0;
      ext <= 16'h0f0f;
      wr(PGPIO_IDX_DATA_LOW, 16'h5555, PGPIO_RESP_OKAY);
      chk("pins", port_pin_in, 32'h0f0f);
      rd(PGPIO_IDX_DATA_LOW, 32'h0f0f, PGPIO_RESP_OKAY);
      low_output_enable <= 16'h00ff;
      low_direction <= 16'h00ff;
      ext <= 16'hab00;
      // new pin level needs two edges through the synchroniser
      repeat (2) @(posedge aclk);
      rd(PGPIO_IDX_DATA_LOW, 32'hab55, PGPIO_RESP_OKAY);
      chk("pins", port_pin_in, 32'hab55);
      $display("test input mode done");
      wr(16'h4408, 16'h1111, PGPIO_RESP_SLVERR);
      rd(16'h4404, 32'h0, PGPIO_RESP_SLVERR);
      rd(PGPIO_IDX_DATA_LOW, 32'hab55, PGPIO_RESP_OKAY);
      $display("test unmapped done");
      // upper byte strobe only: low byte of the enable register keeps its ones
      s_axil_wstrb <= 4'h2;
      wr(PGPIO_IDX_OE_HIGH, 16'h0000, PGPIO_RESP_OKAY);
      rd(PGPIO_IDX_OE_HIGH, 32'h00ff, PGPIO_RESP_OKAY);
      s_axil_wstrb <= 4'hf;
      $display("test strobes done");
      // reset in mid-run: data reloads the pin level, control clears
      aresetn <= 1'b0;
      low_output_enable <= 16'h0;
      low_direction <= 16'h0;
      ext <= 16'h3c3c;
      repeat (3) @(posedge aclk);
      chk("out", port_pin_drive.out, 32'h3c3c);
      aresetn <= 1'b1;
      rd(PGPIO_IDX_OE_HIGH, 32'h0, PGPIO_RESP_OKAY);
      rd(PGPIO_IDX_DIR_HIGH, 32'h0, PGPIO_RESP_OKAY);
      chk("out", port_pin_drive.out, 32'h3c3c);
      rd(PGPIO_IDX_DATA_LOW, 32'h3c3c, PGPIO_RESP_OKAY);
      $display("test mid-run reset done");
      conclude();
   end
endmodule
`default_nettype wire
